// ==== bga_bus_master.sv ====
// Crate master model: drives the backplane pins of the slave and reads its answers.
// Assumes the slave's data drive, data enable and acknowledge enable are fed back here.
`timescale 1ns/1ps
module bga_bus_master (
  input wire logic clock,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic dtack_oe,
  output bga_pkg::bga_vme_in_s bus
);
  bga_pkg::bga_vme_in_s pins;
  logic [31:0] drive_data;
  // Data lines carry the slave's word while it drives them, else the master's.
  always_comb begin
    bus = pins;
    bus.data = data_oe ? data_out : drive_data;
  end
  // Idle lines: strobes released high, no cycle in progress.
  initial begin
    pins = '0;
    pins.as_n = 1'b1;
    pins.ds_n = 2'h3;
    pins.write_n = 1'b1;
    pins.iack_n = 1'b1;
    pins.iackin_n = 1'b1;
    drive_data = 32'h0;
  end
  // Puts out address bits 31 to 1 and its modifier, then the address strobe.
  task automatic open_cycle(input logic [5:0] am, input logic [31:0] addr,
      input logic write, input logic iack);
    @(posedge clock) #1;
    pins.addr = addr[31:1];
    pins.am = am;
    pins.write_n = ~write;
    pins.iack_n = ~iack;
    pins.iackin_n = ~iack;
    @(posedge clock) #1;
    pins.as_n = 1'b0;
    repeat (2) @(posedge clock);
  endtask : open_cycle
  // One data beat: both lanes for words, the odd lane for an acknowledge.
  task automatic beat(input logic [31:0] wdata, input logic iack,
      output logic [31:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 32'h0;
    @(posedge clock) #1;
    drive_data = wdata;
    pins.ds_n = iack ? 2'h2 : 2'h0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clock);
      if (dtack_oe === 1'b1) begin
        ok = 1'b1;
        rdata = bus.data;
      end
    end
    #1;
    pins.ds_n = 2'h3;
    drive_data = ~wdata;
    for (n = 0; n < 20 && dtack_oe === 1'b1; n++) @(posedge clock);
  endtask : beat
  // Ends the cycle; the address lines no longer hold their last value.
  task automatic close_cycle();
    @(posedge clock) #1;
    pins.as_n = 1'b1;
    pins.iack_n = 1'b1;
    pins.iackin_n = 1'b1;
    pins.addr = ~pins.addr;
    repeat (4) @(posedge clock);
  endtask : close_cycle
endmodule : bga_bus_master

// ==== bga_i2c.sv ====
// Two-wire serial master that carries one address byte and one data byte.
// Assumes open-drain pins resolved outside; the data pin arrives asynchronously.
`timescale 1ns/1ps
`include "bga_map.svh"
module bga_i2c (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [6:0] dev_addr,
  input wire logic rnw,
  input wire logic [7:0] wdata,
  input wire logic sda_in,
  output logic busy,
  output logic [7:0] rdata,
  output logic scl_oe,
  output logic sda_oe
);
  typedef struct packed {
    bga_pkg::bga_i2c_e st;
    logic [9:0] tmr;
    logic phase;
    logic [4:0] idx;
    logic [17:0] sh;
    logic [7:0] rx;
    logic [1:0] sync;
    logic scl_oe;
    logic sda_oe;
  } bga_i2c_s;
  localparam logic [9:0] HALF = 10'(`BGA_I2C_HALF_CYC - 1);
  bga_i2c_s r_reg, r_next;
  logic half_done;
  assign half_done = (r_reg.tmr == HALF);
  assign busy = (r_reg.st != bga_pkg::I_IDLE);
  assign rdata = r_reg.rx;
  assign scl_oe = r_reg.scl_oe;
  assign sda_oe = r_reg.sda_oe;
  // Bit sequencer: each bit is a low half then a high half of the clock line.
  always_comb begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[0], sda_in};
    r_next.tmr = half_done ? 10'h000 : r_reg.tmr + 10'h001;
    unique case (r_reg.st)
      bga_pkg::I_IDLE: begin
        r_next.tmr = 10'h000;
        if (start) begin
          r_next.st = bga_pkg::I_START;
          r_next.sda_oe = 1'b1;
          r_next.sh = {dev_addr, rnw, 1'b1, rnw ? 8'hFF : wdata, 1'b1};
          r_next.idx = 5'h00;
          r_next.phase = 1'b0;
        end
      end
      bga_pkg::I_START: begin
        if (half_done) begin
          r_next.st = bga_pkg::I_BIT;
          r_next.scl_oe = 1'b1;
        end
      end
      bga_pkg::I_BIT: begin
        if (half_done && !r_reg.phase) begin
          r_next.phase = 1'b1;
          r_next.scl_oe = 1'b0;
        end else if (half_done) begin
          r_next.phase = 1'b0;
          r_next.scl_oe = 1'b1;
          if (r_reg.idx >= 5'h09 && r_reg.idx <= 5'h10) begin
            r_next.rx = {r_reg.rx[6:0], r_reg.sync[1]};
          end
          r_next.sh = {r_reg.sh[16:0], 1'b1};
          r_next.idx = r_reg.idx + 5'h01;
          if (r_reg.idx == 5'h11) begin
            r_next.st = bga_pkg::I_STOP;
            r_next.sda_oe = 1'b1;
          end
        end else if (!r_reg.phase) begin
          r_next.sda_oe = ~r_reg.sh[17];
        end
      end
      bga_pkg::I_STOP: begin
        if (half_done && !r_reg.phase) begin
          r_next.phase = 1'b1;
          r_next.scl_oe = 1'b0;
        end else if (half_done) begin
          r_next.sda_oe = 1'b0;
          r_next.st = bga_pkg::I_IDLE;
        end
      end
    endcase
  end
  // State register.
  always_ff @(posedge clock) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.st <= bga_pkg::I_IDLE;
      r_reg.sync <= 2'h3;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : bga_i2c

// ==== bga_map.svh ====
// Constants of the backplane slave: offsets, field positions, identity values, timings.
// Assumes inclusion by the design modules of this block.
`ifndef BGA_MAP_SVH
`define BGA_MAP_SVH
`define BGA_CLK_NS 5
`define BGA_I2C_HALF_NS 5000
`define BGA_I2C_HALF_CYC ((`BGA_I2C_HALF_NS + `BGA_CLK_NS - 1) / `BGA_CLK_NS)
`define BGA_AM_A32_SGL_U 6'h09
`define BGA_AM_A32_SGL_S 6'h0D
`define BGA_AM_A32_BLT_U 6'h0B
`define BGA_AM_A32_BLT_S 6'h0F
`define BGA_AM_CRCSR 6'h2F
`define BGA_OFS_CTRL 20'h00000
`define BGA_OFS_INT 20'h00004
`define BGA_OFS_STAT 20'h00008
`define BGA_OFS_I2C 20'h0000C
`define BGA_RAM_BASE 6'h01
`define BGA_CR_ID0 19'h0001F
`define BGA_CR_ID1 19'h00023
`define BGA_CSR_BAR 19'h7FFFF
`define BGA_CR_ID0_VAL 8'h43
`define BGA_CR_ID1_VAL 8'h52
`define BGA_TTC_LOW 6'h06
`define BGA_RAM_WAIT 3'h4
`define BGA_INT_LEVEL_LSB 8
`define BGA_I2C_RNW_BIT 16
`define BGA_I2C_BUSY_BIT 31
`endif

// ==== bga_pkg.sv ====
// Types of the backplane slave: states, address spaces, pin groups and identity records.
// Assumes bga_map.svh is reachable by bare name.
package bga_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_WAIT_DS = 5'h02, S_RAM = 5'h04, S_ACK = 5'h08, S_PASS = 5'h10
  } bga_slv_e;
  typedef enum logic [3:0] {
    I_IDLE = 4'h1, I_START = 4'h2, I_BIT = 4'h4, I_STOP = 4'h8
  } bga_i2c_e;
  typedef enum logic [1:0] {SP_NONE = 2'h0, SP_REG = 2'h1, SP_RAM = 2'h2, SP_CSR = 2'h3} bga_space_e;
  // Backplane input pins, sampled as one group.
  typedef struct packed {
    logic [31:1] addr;
    logic [5:0] am;
    logic [31:0] data;
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic iack_n;
    logic iackin_n;
  } bga_vme_in_s;
  // Identities derived from the geographical address.
  typedef struct packed {
    logic [13:0] ttc_addr;
    logic [7:0] can_node;
    logic [31:0] vme_base;
    logic [23:0] csr_base;
    logic [2:0] fw_sel;
    logic crate;
  } bga_geo_s;
endpackage : bga_pkg

// ==== bga_slave.sv ====
// Backplane slave: geographical decode, register and results-memory access,
// configuration space, interrupter with latched sources and timing-receiver
// serial access. Assumes backplane pins resolved outside from output enables.
`timescale 1ns/1ps
`include "bga_map.svh"
module bga_slave (
  input wire logic clock,
  input wire logic reset,
  input wire logic [4:0] ga_n,
  input wire logic [2:0] crate_number_line,
  input wire bga_pkg::bga_vme_in_s vme_in,
  input wire logic [2:0] irq_source,
  input wire logic [31:0] ram_rdata,
  input wire logic i2c_sda_in,
  output logic [31:0] vme_data_out,
  output logic vme_data_oe,
  output logic vme_dtack_oe,
  output logic vme_iackout_n,
  output logic [7:1] vme_irq_oe,
  output logic [15:0] ram_addr,
  output logic ram_rd,
  output logic aux_out,
  output logic [1:0] clock_select,
  output bga_pkg::bga_geo_s geo,
  output logic i2c_scl_out,
  output logic i2c_scl_oe,
  output logic i2c_sda_out,
  output logic i2c_sda_oe
);
  typedef struct packed {
    bga_pkg::bga_slv_e st;
    bga_pkg::bga_vme_in_s v1;
    bga_pkg::bga_vme_in_s v2;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [31:0] m1;
    logic [31:0] m2;
    logic [31:0] a_addr;
    logic a_wr;
    logic a_blt;
    bga_pkg::bga_space_e a_sp;
    logic [2:0] cnt;
    logic aux;
    logic [1:0] clk_sel;
    logic [7:0] vector;
    logic [2:0] level;
    logic [2:0] latched;
    logic pend;
    logic [31:0] dout;
    logic doe;
    logic dtack;
    logic iackout_n;
    logic [7:1] irq_oe;
    logic [15:0] ram_addr;
    logic ram_rd;
    logic i2c_go;
    logic [6:0] i2c_dev;
    logic i2c_rnw;
    logic [7:0] i2c_wd;
    bga_pkg::bga_geo_s geo;
  } bga_st_s;
  bga_st_s r_reg, r_next;
  logic i2c_busy;
  logic [7:0] i2c_rdata;
  logic [5:0] ga6;
  logic [31:0] rd_val;
  logic wr_int;
  logic [2:0] new_src;

  // ****************************************
  // Helper functions
  // ****************************************
  // Default firmware collection chosen from the slot number.
  function automatic logic [2:0] fw_of(input logic [4:0] slot);
    if (slot >= 5'h03 && slot <= 5'h09) return 3'h0;
    if (slot >= 5'h0A && slot <= 5'h0D) return 3'h3;
    if (slot >= 5'h0E && slot <= 5'h0F) return 3'h4;
    if (slot >= 5'h10 && slot <= 5'h12) return 3'h5;
    if (slot >= 5'h13 && slot <= 5'h14) return 3'h6;
    return 3'h7;
  endfunction : fw_of

  // Address space that an access with the given modifier and address hits.
  function automatic bga_pkg::bga_space_e space_of(input logic [5:0] am,
                                                   input logic [31:0] a,
                                                   input logic [4:0] slot);
    logic a32;
    a32 = (am == `BGA_AM_A32_SGL_U) || (am == `BGA_AM_A32_SGL_S) ||
          (am == `BGA_AM_A32_BLT_U) || (am == `BGA_AM_A32_BLT_S);
    if (am == `BGA_AM_CRCSR && a[23:19] == slot) return bga_pkg::SP_CSR;
    if (!a32 || a[31:26] != {1'b0, slot}) return bga_pkg::SP_NONE;
    if (a[25:18] == {2'h0, `BGA_RAM_BASE}) return bga_pkg::SP_RAM;
    if (a[25:20] == 6'h00) return bga_pkg::SP_REG;
    return bga_pkg::SP_NONE;
  endfunction : space_of

  // ****************************************
  // Derived values
  // ****************************************
  // Crate bit from the lowest crate line only, with the five slot lines.
  assign ga6 = r_reg.g2[5:0];
  assign wr_int = (r_reg.st == bga_pkg::S_WAIT_DS) && r_reg.v2.ds_n == 2'h0 && !r_reg.a_blt &&
                  r_reg.a_sp == bga_pkg::SP_REG && r_reg.a_wr &&
                  r_reg.a_addr[19:0] == `BGA_OFS_INT;
  assign new_src = irq_source & ~r_reg.latched;

  // Read value for register and configuration space.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (r_reg.a_sp == bga_pkg::SP_CSR) begin
      unique case ({r_reg.a_addr[18:2], 2'h3})
        `BGA_CR_ID0: rd_val = {24'h000000, `BGA_CR_ID0_VAL};
        `BGA_CR_ID1: rd_val = {24'h000000, `BGA_CR_ID1_VAL};
        `BGA_CSR_BAR: rd_val = {24'h000000, ga6[4:0], 3'h0};
        default: rd_val = 32'h0000_0000;
      endcase
    end else begin
      unique case (r_reg.a_addr[19:0])
        `BGA_OFS_CTRL: rd_val = {29'h0, r_reg.clk_sel, r_reg.aux};
        `BGA_OFS_INT: rd_val = {21'h0, r_reg.level, r_reg.vector};
        `BGA_OFS_STAT: rd_val = {22'h0, ga6, r_reg.pend, r_reg.latched};
        `BGA_OFS_I2C: rd_val = {i2c_busy, 23'h0, i2c_rdata};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  // Pin synchronisers, identities, interrupter and the slave cycle machine.
  always_comb begin
    r_next = r_reg;
    r_next.v1 = vme_in;
    r_next.v2 = r_reg.v1;
    r_next.g1 = {~crate_number_line, ~ga_n};
    r_next.g2 = r_reg.g1;
    r_next.m1 = ram_rdata;
    r_next.m2 = r_reg.m1;
    r_next.i2c_go = 1'b0;
    // Identities from slot and crate bit.
    r_next.geo.ttc_addr = {2'h0, ga6, `BGA_TTC_LOW};
    r_next.geo.can_node = {2'h0, ga6};
    r_next.geo.vme_base = {1'b0, ga6[4:0], 26'h0000000};
    r_next.geo.csr_base = {ga6[4:0], 19'h00000};
    r_next.geo.fw_sel = fw_of(ga6[4:0]);
    r_next.geo.crate = ga6[5];
    // Latched sources: a new event wins over a clear in the same cycle.
    r_next.latched = (r_reg.latched & {3{~wr_int}}) | new_src;
    if (wr_int) r_next.pend = 1'b0;
    if (new_src != 3'h0) r_next.pend = 1'b1;
    unique case (r_reg.st)
      bga_pkg::S_IDLE: begin
        if (!r_reg.v2.as_n) begin
          r_next.a_addr = {r_reg.v2.addr, 1'b0};
          r_next.a_wr = !r_reg.v2.write_n;
          r_next.a_blt = (r_reg.v2.am == `BGA_AM_A32_BLT_U) ||
                         (r_reg.v2.am == `BGA_AM_A32_BLT_S);
          r_next.a_sp = space_of(r_reg.v2.am, {r_reg.v2.addr, 1'b0}, ga6[4:0]);
          r_next.st = bga_pkg::S_WAIT_DS;
        end
      end
      bga_pkg::S_WAIT_DS: begin
        if (r_reg.v2.as_n) begin
          r_next.st = bga_pkg::S_IDLE;
        end else if (!r_reg.v2.iack_n && !r_reg.v2.ds_n[0] && !r_reg.v2.iackin_n) begin
          if (r_reg.pend && r_reg.level != 3'h0 && r_reg.a_addr[3:1] == r_reg.level) begin
            r_next.dout = {24'h000000, r_reg.vector};
            r_next.doe = 1'b1;
            r_next.dtack = 1'b1;
            r_next.pend = (new_src != 3'h0);
            r_next.st = bga_pkg::S_ACK;
          end else begin
            r_next.iackout_n = 1'b0;
            r_next.st = bga_pkg::S_PASS;
          end
        end else if (!r_reg.v2.iack_n || r_reg.v2.ds_n != 2'h0) begin
          r_next.st = r_reg.st;
        end else if (r_reg.a_sp == bga_pkg::SP_NONE ||
                     (r_reg.a_blt && r_reg.a_sp != bga_pkg::SP_RAM)) begin
          r_next.st = bga_pkg::S_PASS;
        end else if (r_reg.a_sp == bga_pkg::SP_RAM) begin
          if (r_reg.a_wr) begin
            r_next.st = bga_pkg::S_PASS;
          end else begin
            r_next.ram_addr = r_reg.a_addr[17:2];
            r_next.ram_rd = 1'b1;
            r_next.cnt = 3'h0;
            r_next.st = bga_pkg::S_RAM;
          end
        end else begin
          r_next.dtack = 1'b1;
          r_next.st = bga_pkg::S_ACK;
          if (!r_reg.a_wr) begin
            r_next.dout = rd_val;
            r_next.doe = 1'b1;
          end else if (r_reg.a_sp == bga_pkg::SP_REG) begin
            unique case (r_reg.a_addr[19:0])
              `BGA_OFS_CTRL: begin
                r_next.aux = r_reg.v2.data[0];
                r_next.clk_sel = r_reg.v2.data[2:1];
              end
              `BGA_OFS_INT: begin
                r_next.vector = r_reg.v2.data[7:0];
                r_next.level = r_reg.v2.data[`BGA_INT_LEVEL_LSB +: 3];
              end
              `BGA_OFS_I2C: begin
                r_next.i2c_go = !i2c_busy;
                r_next.i2c_wd = r_reg.v2.data[7:0];
                r_next.i2c_dev = r_reg.v2.data[14:8];
                r_next.i2c_rnw = r_reg.v2.data[`BGA_I2C_RNW_BIT];
              end
              default: r_next.aux = r_reg.aux;
            endcase
          end
        end
      end
      bga_pkg::S_RAM: begin
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == `BGA_RAM_WAIT) begin
          r_next.ram_rd = 1'b0;
          r_next.dout = r_reg.m2;
          r_next.doe = 1'b1;
          r_next.dtack = 1'b1;
          r_next.st = bga_pkg::S_ACK;
        end
      end
      bga_pkg::S_ACK: begin
        if (r_reg.v2.ds_n == 2'h3) begin
          r_next.dtack = 1'b0;
          r_next.doe = 1'b0;
          if (!r_reg.v2.as_n && r_reg.a_blt) begin
            r_next.a_addr = r_reg.a_addr + 32'h0000_0004;
            r_next.st = bga_pkg::S_WAIT_DS;
          end else begin
            r_next.st = bga_pkg::S_PASS;
          end
        end
      end
      bga_pkg::S_PASS: begin
        if (r_reg.v2.as_n) begin
          r_next.iackout_n = 1'b1;
          r_next.st = bga_pkg::S_IDLE;
        end
      end
      default: r_next.st = bga_pkg::S_IDLE;
    endcase
    // Drive the chosen request line only while a request is pending.
    r_next.irq_oe = 7'h00;
    if (r_next.pend && r_reg.level != 3'h0) begin
      r_next.irq_oe = 7'(8'h01 << r_reg.level >> 1);
    end
  end

  // State register with reset values.
  always_ff @(posedge clock) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.st <= bga_pkg::S_IDLE;
      r_reg.iackout_n <= 1'b1;
      r_reg.v1.as_n <= 1'b1;
      r_reg.v2.as_n <= 1'b1;
      r_reg.v1.ds_n <= 2'h3;
      r_reg.v2.ds_n <= 2'h3;
      r_reg.v1.iack_n <= 1'b1;
      r_reg.v2.iack_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // Serial access to the timing receiver
  // ****************************************
  bga_i2c u_i2c (
    .clock(clock),
    .reset(reset),
    .start(r_reg.i2c_go),
    .dev_addr(r_reg.i2c_dev),
    .rnw(r_reg.i2c_rnw),
    .wdata(r_reg.i2c_wd),
    .sda_in(i2c_sda_in),
    .busy(i2c_busy),
    .rdata(i2c_rdata),
    .scl_oe(i2c_scl_oe),
    .sda_oe(i2c_sda_oe)
  );

  // Outputs straight from the state register; the serial clock and data levels are tied low.
  assign vme_data_out = r_reg.dout;
  assign vme_data_oe = r_reg.doe;
  assign vme_dtack_oe = r_reg.dtack;
  assign vme_iackout_n = r_reg.iackout_n;
  assign vme_irq_oe = r_reg.irq_oe;
  assign ram_addr = r_reg.ram_addr;
  assign ram_rd = r_reg.ram_rd;
  assign aux_out = r_reg.aux;
  assign clock_select = r_reg.clk_sel;
  assign geo = r_reg.geo;
  assign i2c_scl_out = 1'b0;
  assign i2c_sda_out = 1'b0;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_ack_hit;
    r_reg.st == bga_pkg::S_WAIT_DS && r_next.st == bga_pkg::S_ACK && !r_reg.v2.iack_n &&
      new_src == 3'h0;
  endsequence
  sequence s_released;
    vme_irq_oe == 7'h00 && vme_data_out[7:0] == $past(r_reg.vector);
  endsequence
  AST_TTC_LOW: assert property (!$past(reset) |->
      geo.ttc_addr[5:0] == 6'h06 && geo.ttc_addr[13:12] == 2'h0)
    else $error("receiver address low pattern wrong");
  AST_BASE: assert property (##3 geo.vme_base == {1'b0, $past(r_reg.g2[4:0]), 26'h0})
    else $error("module window base wrong");
  AST_CSR: assert property (geo.csr_base[18:0] == 19'h0 && geo.csr_base[23:19] == geo.vme_base[30:26])
    else $error("configuration base wrong");
  AST_ROAK: assert property (s_ack_hit |=> s_released)
    else $error("request not released with vector on acknowledge");
  AST_IRQ_LINE: assert property (vme_irq_oe != 7'h00 |->
      vme_irq_oe == 7'(8'h01 << $past(r_reg.level) >> 1))
    else $error("request on wrong line");
  AST_LATCH_HOLD: assert property (r_reg.latched[0] && !wr_int |=> r_reg.latched[0])
    else $error("latched source lost without clear");
  AST_CLEAR: assert property (wr_int && irq_source == 3'h0 |=> r_reg.latched == 3'h0 && !r_reg.pend)
    else $error("interrupt register write did not clear");
  AST_AUX: assert property (r_reg.st == bga_pkg::S_WAIT_DS && r_next.dtack && r_reg.a_wr &&
      r_reg.a_sp == bga_pkg::SP_REG && r_reg.a_addr[19:0] == `BGA_OFS_CTRL
      |=> aux_out == $past(r_reg.v2.data[0]))
    else $error("auxiliary output not set by write");
  AST_BLT_REG: assert property (r_reg.st == bga_pkg::S_WAIT_DS && r_reg.a_blt &&
      r_reg.a_sp == bga_pkg::SP_REG |=> !vme_dtack_oe)
    else $error("block transfer answered outside memory");
endmodule : bga_slave

// ==== test_backplane_slave_geo_addressing.sv ====
// Self-checking bench of the backplane slave with a crate master model.
// Assumes bga_pkg, bga_slave and bga_bus_master are compiled before this file.
`timescale 1ns/1ps
module test_backplane_slave_geo_addressing;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] ga_n = 5'h1C;
  logic [2:0] crate_number_line = 3'h7;
  logic [2:0] irq_source = 3'h0;
  logic [31:0] ram_rdata = 32'h0;
  logic [31:0] vme_data_out, rd;
  logic vme_data_oe, vme_dtack_oe, vme_iackout_n, ram_rd, aux_out, ok;
  logic i2c_scl_oe, i2c_sda_oe;
  logic [7:1] vme_irq_oe;
  logic [15:0] ram_addr;
  logic [1:0] clock_select;
  logic [31:0] base;
  bga_pkg::bga_vme_in_s vme_in;
  bga_pkg::bga_geo_s geo;
  int fail_count = 0;
  int cmp_count = 0;
  // ****************************************
  // Clock, design, master and memory
  // ****************************************
  // The clock toggles every half period of 2.5 ns.
  always #2.5 clock = ~clock;
  bga_slave uut (.clock(clock), .reset(reset), .ga_n(ga_n),
    .crate_number_line(crate_number_line), .vme_in(vme_in), .irq_source(irq_source),
    .ram_rdata(ram_rdata), .i2c_sda_in(~i2c_sda_oe), .vme_data_out(vme_data_out),
    .vme_data_oe(vme_data_oe), .vme_dtack_oe(vme_dtack_oe), .vme_iackout_n(vme_iackout_n),
    .vme_irq_oe(vme_irq_oe), .ram_addr(ram_addr), .ram_rd(ram_rd), .aux_out(aux_out),
    .clock_select(clock_select), .geo(geo), .i2c_scl_out(), .i2c_scl_oe(i2c_scl_oe),
    .i2c_sda_out(), .i2c_sda_oe(i2c_sda_oe));
  bga_bus_master m (.clock(clock), .data_out(vme_data_out), .data_oe(vme_data_oe),
    .dtack_oe(vme_dtack_oe), .bus(vme_in));
  // The results memory answers each read with a word that carries its address.
  always @(posedge clock) if (ram_rd) ram_rdata <= {16'hCAFE, ram_addr};
  // ****************************************
  // Tasks
  // ****************************************
  // Compares and counts; a difference is reported at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single cycle through the master.
  task automatic acc(input logic [5:0] am, input logic [31:0] addr, input logic write,
      input logic [31:0] wdata);
    m.open_cycle(am, addr, write, 1'b0);
    m.beat(wdata, 1'b0, rd, ok);
    m.close_cycle();
  endtask : acc
  // An acknowledge cycle on one request level.
  task automatic iack(input logic [2:0] lvl);
    m.open_cycle(6'h00, {28'h0, lvl, 1'b0}, 1'b0, 1'b1);
    m.beat(32'h0, 1'b1, rd, ok);
  endtask : iack
  // One cycle of request from the chosen sources.
  task automatic pulse(input logic [2:0] src);
    @(posedge clock) #1;
    irq_source = src;
    @(posedge clock) #1;
    irq_source = 3'h0;
    repeat (4) @(posedge clock);
  endtask : pulse
  // Sets slot and crate lines and checks every identity derived from them.
  task automatic geo_set(input logic [4:0] slot, input logic crate, input logic [2:0] fw);
    @(posedge clock) #1;
    ga_n = ~slot;
    crate_number_line = {2'h3, ~crate};
    repeat (10) @(posedge clock);
    base = {1'b0, slot, 26'h0};
    check("ttc", geo.ttc_addr, {crate, slot, 6'h06});
    check("base", geo.vme_base, base);
    check("csr", geo.csr_base, {slot, 19'h0});
    check("node", geo.can_node, {2'h0, crate, slot});
    check("fw", geo.fw_sel, fw);
    check("crate", geo.crate, crate);
  endtask : geo_set
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // ****************************************
  // Tests
  // ****************************************
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    stop_test();
  end
  // Main sequence of bus cycles and events.
  initial begin
    repeat (20) @(posedge clock);
    #1 reset = 1'b0;
    repeat (6) @(posedge clock);
    geo_set(5'h03, 1'b0, 3'h0);
    acc(6'h09, base, 1'b1, 32'h5);
    check("aux", aux_out, 1'b1);
    check("clksel", clock_select, 2'h2);
    acc(6'h0D, base, 1'b1, 32'h2);
    check("aux", aux_out, 1'b0);
    check("clksel", clock_select, 2'h1);
    acc(6'h2F, 32'h0018001C, 1'b0, 32'h0);
    check("crid", rd, 32'h43);
    acc(6'h2F, 32'h001FFFFC, 1'b0, 32'h0);
    check("csrbar", rd, 32'h18);
    acc(6'h09, base + 32'h100000, 1'b0, 32'h0);
    check("unmapped", ok, 1'b0);
    acc(6'h09, base + 32'h40000, 1'b1, 32'h1);
    check("ramwr", ok, 1'b0);
    acc(6'h09, base ^ 32'h04000000, 1'b0, 32'h0);
    check("other", ok, 1'b0);
    acc(6'h0B, base, 1'b0, 32'h0);
    check("bltreg", ok, 1'b0);
    acc(6'h09, base + 32'h40014, 1'b0, 32'h0);
    check("ram", rd, 32'hCAFE0005);
    m.open_cycle(6'h0F, base + 32'h4001C, 1'b0, 1'b0);
    for (int k = 7; k < 10; k++) begin
      m.beat(32'h0, 1'b0, rd, ok);
      check("blt", rd, {16'hCAFE, 16'(k)});
    end
    m.close_cycle();
    acc(6'h09, base + 32'h4, 1'b1, 32'h3A5);
    pulse(3'h4);
    check("irq", vme_irq_oe, 7'h04);
    iack(3'h5);
    check("wrong", ok, 1'b0);
    check("chain", vme_iackout_n, 1'b0);
    m.close_cycle();
    iack(3'h3);
    check("vector", rd, 32'hA5);
    m.close_cycle();
    check("roak", vme_irq_oe, 7'h00);
    acc(6'h09, base + 32'h8, 1'b0, 32'h0);
    check("stat", rd & 32'h3FF, 32'h34);
    pulse(3'h4);
    check("block", vme_irq_oe, 7'h00);
    acc(6'h09, base + 32'h4, 1'b1, 32'h73C);
    acc(6'h09, base + 32'h8, 1'b0, 32'h0);
    check("clear", rd & 32'hF, 32'h0);
    pulse(3'h5);
    check("irq7", vme_irq_oe, 7'h40);
    iack(3'h7);
    check("vector7", rd, 32'h3C);
    m.close_cycle();
    pulse(3'h2);
    check("irq7b", vme_irq_oe, 7'h40);
    acc(6'h09, base + 32'hC, 1'b1, 32'h655);
    acc(6'h09, base + 32'hC, 1'b0, 32'h0);
    check("i2cbusy", rd[31], 1'b1);
    check("i2cstart", i2c_sda_oe, 1'b1);
    acc(6'h09, base, 1'b1, 32'h1);
    @(posedge clock) #1 reset = 1'b1;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    check("rsti2c", i2c_sda_oe, 1'b0);
    check("rstirq", vme_irq_oe, 7'h00);
    check("rstaux", aux_out, 1'b0);
    check("rstclk", clock_select, 2'h0);
    repeat (6) @(posedge clock);
    geo_set(5'h12, 1'b1, 3'h5);
    geo_set(5'h0B, 1'b0, 3'h3);
    acc(6'h09, base, 1'b1, 32'h1);
    check("newbase", aux_out, 1'b1);
    stop_test();
  end
endmodule : test_backplane_slave_geo_addressing
